// file: common/ebr_pkg.sv
// What this block does
// - Synchronous mode samples ready directly on the reference clock; partner drives it synchronously.
// - Asynchronous mode adds a synchroniser stage, costing at least one extra waitstate.
// - Each cycle runs its programmed waitstates before the first ready sample point.
// - Ready sampled high adds a waitstate; ready sampled low ends the cycle.
// - Multiplexed cycles add a turnaround state, optionally followed by a tristate waitstate.
// - Post-cycle delay is two reference cycles multiplexed with tristate, zero demultiplexed without.
// - A bus request waits until the running cycle has finished.
// - On release, chip select is driven high one half period, then left floating.
// - Regain starts only when the external request goes inactive.
// - Regain works even when no regain request was ever raised.
// - In share mode the external master reads and writes the extension RAM.
// - Cycles stretch for programmed waitstates, inactive ready, and a selected tristate state.
package ebr_pkg;
   localparam int unsigned ADDR_W  = 2;
   localparam int unsigned DATA_W  = 16;
   localparam int unsigned MCTC_W  = 4;
   localparam int unsigned RAM_AW  = 4;
   localparam int unsigned RAM_DEPTH = 16;
   localparam int unsigned CNT_W   = 4;

   // Register indices
   localparam logic [ADDR_W-1:0] REG_CTRL = 2'h0;
   localparam logic [ADDR_W-1:0] REG_CMD  = 2'h1;
   localparam logic [ADDR_W-1:0] REG_STAT = 2'h2;

   // Control fields
   localparam int unsigned CTRL_ASYNC   = 0;
   localparam int unsigned CTRL_MUX     = 1;
   localparam int unsigned CTRL_TRI     = 2;
   localparam int unsigned CTRL_SHARE   = 3;
   localparam int unsigned CTRL_NEED    = 4;
   localparam int unsigned CTRL_MCTC_LO = 8;
   localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;
   localparam logic [DATA_W-1:0] CTRL_MASK  = 16'h0F1F;

   // Command and status fields
   localparam int unsigned CMD_START    = 0;
   localparam int unsigned CMD_WRITE    = 1;
   localparam int unsigned STAT_PEND    = 0;
   localparam int unsigned STAT_HELD    = 1;
   localparam int unsigned STAT_DONE_LO = 4;

   localparam logic [MCTC_W-1:0] MCTC_ZERO = 4'h0;
   localparam logic [MCTC_W-1:0] MCTC_ONE  = 4'h1;
   localparam logic [CNT_W-1:0]  DONE_ONE  = 4'h1;
   localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;

   typedef enum logic [3:0] {
      LS_IDLE, LS_ADDR, LS_WAIT, LS_SMP, LS_MUX, LS_TRI, LS_REL, LS_HELD, LS_REGAIN
   } ebr_link_e;
endpackage

// file: hdl/ebr_sync.sv
`timescale 1ns/1ps
// Two-stage level synchroniser; first stage feeds only the second
module ebr_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta;

   // Constant reset values only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule

// file: hdl/ebr_ctrl.sv
`timescale 1ns/1ps
module ebr_ctrl (
   // System clock and reset
   input  wire logic        CLK,
   input  wire logic        RST_N,
   // Register port
   input  wire logic [1:0]  ADDR,
   input  wire logic [15:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic      [15:0] RDATA,
   // Link clock, ticks once per half reference period
   input  wire logic        LCLK,
   output logic             BUS_REF_CLK,
   // Bus cycle
   input  wire logic        READY_N,
   output logic             RD_STROBE_N,
   output logic             WR_STROBE_N,
   output logic             BUS_OE,
   output logic             CS_N,
   output logic             CS_OE,
   // Arbitration
   input  wire logic        HOLD_N,
   output logic             GRANT_ACK_N,
   output logic             REGAIN_REQ_N,
   // Shared extension RAM port
   input  wire logic [3:0]  X_ADDR,
   input  wire logic [15:0] X_DIN,
   input  wire logic        X_RD_N,
   input  wire logic        X_WR_N,
   output logic      [15:0] X_DOUT,
   output logic             X_DOE
);
   localparam int unsigned XS_W = ebr_pkg::RAM_AW + ebr_pkg::DATA_W + 2;

   // ---------------- System clock domain ----------------
   logic [15:0]             ctrl;
   logic [15:0]             cmd_word;
   logic                    cmd_write;
   logic                    pend;
   logic                    req_tgl;
   logic                    done_seen;
   logic [3:0]              done_cnt;
   logic                    done_s;
   logic                    held_s;
   logic [XS_W-1:0]         xs;
   logic                    xwr_prev;
   logic [15:0]             ram [ebr_pkg::RAM_DEPTH];

   // Link domain state visible here only through synchronisers
   logic                    done_tgl;
   logic                    held;

   // Address decode
   wire sel_ctrl  = (ADDR == ebr_pkg::REG_CTRL);
   wire sel_cmd   = (ADDR == ebr_pkg::REG_CMD);
   wire sel_stat  = (ADDR == ebr_pkg::REG_STAT);
   wire wr_ctrl   = WR && sel_ctrl;
   wire start     = WR && sel_cmd && WDATA[ebr_pkg::CMD_START] && !pend;
   wire done_evt  = (done_s != done_seen);
   wire [15:0] stat_word = {8'h00, done_cnt, 2'b00, held_s, pend};
   wire [15:0] next_rdata;
   assign next_rdata = !RD     ? ebr_pkg::DATA_ZERO :
                       sel_ctrl ? ctrl :
                       sel_cmd  ? {14'h0000, cmd_write, pend} :
                       sel_stat ? stat_word : ebr_pkg::DATA_ZERO;

   // Returning events and levels from the link side
   ebr_sync #(.W(2)) u_back (
      .clk   (CLK),
      .rst_n (RST_N),
      .d     ({done_tgl, held}),
      .q     ({done_s, held_s})
   );

   // Registers; the command snapshot stays stable while a request is pending
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ctrl      <= ebr_pkg::CTRL_RESET;
         cmd_word  <= ebr_pkg::CTRL_RESET;
         cmd_write <= 1'b0;
         pend      <= 1'b0;
         req_tgl   <= 1'b0;
         done_seen <= 1'b0;
         done_cnt  <= '0;
         RDATA     <= ebr_pkg::DATA_ZERO;
      end else begin
         RDATA     <= next_rdata;
         done_seen <= done_s;
         if (wr_ctrl) begin
            ctrl <= WDATA & ebr_pkg::CTRL_MASK;
         end
         if (start) begin
            cmd_word  <= ctrl;
            cmd_write <= WDATA[ebr_pkg::CMD_WRITE];
            req_tgl   <= ~req_tgl;
            pend      <= 1'b1;
         end else if (done_evt) begin
            pend     <= 1'b0;
            done_cnt <= done_cnt + ebr_pkg::DONE_ONE;
         end
      end
   end

   // Extension RAM pins pass two stages together, so address and data keep alignment
   ebr_sync #(.W(XS_W)) u_xin (
      .clk   (CLK),
      .rst_n (RST_N),
      .d     ({X_RD_N, X_WR_N, X_ADDR, X_DIN}),
      .q     (xs)
   );

   wire                xrd_n    = xs[XS_W-1];
   wire                xwr_n    = xs[XS_W-2];
   wire [3:0]          xaddr    = xs[ebr_pkg::DATA_W +: ebr_pkg::RAM_AW];
   wire [15:0]         xdata    = xs[ebr_pkg::DATA_W-1:0];
   wire                share_ok = ctrl[ebr_pkg::CTRL_SHARE] && held_s;
   wire                xwr_done = xwr_n && !xwr_prev && share_ok;

   // Write lands on the trailing edge of the strobe, where data setup is promised
   always_ff @(posedge CLK) begin
      if (xwr_done) begin
         ram[xaddr] <= xdata;
      end
   end

   // Read port behaves as a static RAM while the bus is granted away
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         xwr_prev <= 1'b1;
         X_DOE    <= 1'b0;
         X_DOUT   <= ebr_pkg::DATA_ZERO;
      end else begin
         xwr_prev <= xwr_n;
         X_DOE    <= !xrd_n && share_ok;
         X_DOUT   <= ram[xaddr];
      end
   end

   a_share_read: assert property (@(posedge CLK) disable iff (!RST_N)
      (!xrd_n && share_ok) |=> X_DOE)
      else $error("shared read did not drive data");

   // ---------------- Link clock domain ----------------
   ebr_pkg::ebr_link_e state;
   ebr_pkg::ebr_link_e next_state;
   logic                    ref_clk;
   logic                    req_s;
   logic                    req_seen;
   logic                    pend_l;
   logic [3:0]              cnt;
   logic [3:0]              next_cnt;
   logic                    hold_s;
   logic                    rdy_async;
   logic                    need_s;
   logic                    smp_first;

   // Request toggle and bus-need level from the system side
   ebr_sync #(.W(2)) u_req (
      .clk   (LCLK),
      .rst_n (RST_N),
      .d     ({req_tgl, ctrl[ebr_pkg::CTRL_NEED]}),
      .q     ({req_s, need_s})
   );

   // Extra stage for asynchronous ready, and the external bus request
   ebr_sync #(.W(2)) u_pins (
      .clk   (LCLK),
      .rst_n (RST_N),
      .d     ({HOLD_N, READY_N}),
      .q     ({hold_s, rdy_async})
   );

   // Cycle setup from the stable snapshot
   wire       req_evt = (req_s != req_seen);
   wire       c_async = cmd_word[ebr_pkg::CTRL_ASYNC];
   wire       c_mux   = cmd_word[ebr_pkg::CTRL_MUX];
   wire       c_tri   = cmd_word[ebr_pkg::CTRL_TRI];
   wire [3:0] c_mctc  = cmd_word[ebr_pkg::CTRL_MCTC_LO +: ebr_pkg::MCTC_W];
   wire       rdy_now = c_async ? rdy_async : READY_N;
   // Asynchronous ready never ends a cycle at its first sample point
   wire       ended   = (state == ebr_pkg::LS_SMP) && ref_clk && !rdy_now &&
                        !(c_async && smp_first);

   // Sequencer; most steps advance once per reference period
   always_comb begin
      next_state = state;
      next_cnt   = cnt;
      case (state)
         ebr_pkg::LS_IDLE: begin
            if (ref_clk && !hold_s) begin
               next_state = ebr_pkg::LS_REL;
            end else if (ref_clk && pend_l) begin
               next_state = ebr_pkg::LS_ADDR;
            end
         end
         ebr_pkg::LS_ADDR: begin
            if (ref_clk) begin
               next_state = ebr_pkg::LS_WAIT;
               next_cnt   = c_mctc;
            end
         end
         ebr_pkg::LS_WAIT: begin
            if (ref_clk && cnt == ebr_pkg::MCTC_ZERO) begin
               next_state = ebr_pkg::LS_SMP;
            end else if (ref_clk) begin
               next_cnt = cnt - ebr_pkg::MCTC_ONE;
            end
         end
         ebr_pkg::LS_SMP: begin
            if (ended) begin
               next_state = c_mux ? ebr_pkg::LS_MUX :
                            (c_tri ? ebr_pkg::LS_TRI : ebr_pkg::LS_IDLE);
            end
         end
         ebr_pkg::LS_MUX: begin
            if (ref_clk) begin
               next_state = c_tri ? ebr_pkg::LS_TRI : ebr_pkg::LS_IDLE;
            end
         end
         ebr_pkg::LS_TRI: begin
            if (ref_clk) begin
               next_state = ebr_pkg::LS_IDLE;
            end
         end
         ebr_pkg::LS_REL: begin
            next_state = ebr_pkg::LS_HELD;
         end
         ebr_pkg::LS_HELD: begin
            if (hold_s) begin
               next_state = ebr_pkg::LS_REGAIN;
            end
         end
         ebr_pkg::LS_REGAIN: begin
            if (ref_clk) begin
               next_state = ebr_pkg::LS_IDLE;
            end
         end
         default: begin
            next_state = ebr_pkg::LS_IDLE;
         end
      endcase
   end

   // Output decode from the next state, so every pin comes from a flop
   wire in_cycle   = (next_state == ebr_pkg::LS_ADDR) || (next_state == ebr_pkg::LS_WAIT) ||
                     (next_state == ebr_pkg::LS_SMP);
   wire strobing   = (next_state == ebr_pkg::LS_WAIT) || (next_state == ebr_pkg::LS_SMP);
   wire next_held  = (next_state == ebr_pkg::LS_HELD);
   wire next_rel   = (next_state == ebr_pkg::LS_REL);
   wire next_regq  = next_held && (pend_l || req_evt || need_s);
   // Completion is reported only after the post-cycle states, so the snapshot stays put
   wire cyc_over   = (next_state == ebr_pkg::LS_IDLE) &&
                     ((state == ebr_pkg::LS_SMP) || (state == ebr_pkg::LS_MUX) ||
                      (state == ebr_pkg::LS_TRI));

   // Link registers
   always_ff @(posedge LCLK or negedge RST_N) begin
      if (!RST_N) begin
         state        <= ebr_pkg::LS_IDLE;
         cnt          <= ebr_pkg::MCTC_ZERO;
         ref_clk      <= 1'b0;
         req_seen     <= 1'b0;
         pend_l       <= 1'b0;
         done_tgl     <= 1'b0;
         held         <= 1'b0;
         smp_first    <= 1'b1;
         BUS_REF_CLK  <= 1'b0;
         RD_STROBE_N  <= 1'b1;
         WR_STROBE_N  <= 1'b1;
         BUS_OE       <= 1'b1;
         CS_N         <= 1'b1;
         CS_OE        <= 1'b1;
         GRANT_ACK_N  <= 1'b1;
         REGAIN_REQ_N <= 1'b1;
      end else begin
         state        <= next_state;
         cnt          <= next_cnt;
         ref_clk      <= ~ref_clk;
         BUS_REF_CLK  <= ~ref_clk;
         req_seen     <= req_s;
         held         <= next_held;
         smp_first    <= (state != ebr_pkg::LS_SMP) || (smp_first && !ref_clk);
         if (req_evt) begin
            pend_l <= 1'b1;
         end else if (state == ebr_pkg::LS_IDLE && next_state == ebr_pkg::LS_ADDR) begin
            pend_l <= 1'b0;
         end
         if (cyc_over) begin
            done_tgl <= ~done_tgl;
         end
         RD_STROBE_N  <= !(strobing && !cmd_write);
         WR_STROBE_N  <= !(strobing && cmd_write);
         BUS_OE       <= !(next_held || next_rel);
         CS_N         <= !in_cycle;
         CS_OE        <= !next_held;
         GRANT_ACK_N  <= !next_held;
         REGAIN_REQ_N <= !next_regq;
      end
   end

   // Link-side checks
   a_ready_ends: assert property (@(posedge LCLK) disable iff (!RST_N)
      ended |=> (state != ebr_pkg::LS_SMP) && RD_STROBE_N && WR_STROBE_N)
      else $error("cycle not ended by low ready");

   a_ready_waits: assert property (@(posedge LCLK) disable iff (!RST_N)
      (state == ebr_pkg::LS_SMP && ref_clk && rdy_now) |=> (state == ebr_pkg::LS_SMP) [*2])
      else $error("high ready did not add a waitstate");

   a_prog_first: assert property (@(posedge LCLK) disable iff (!RST_N)
      (state == ebr_pkg::LS_WAIT && cnt != ebr_pkg::MCTC_ZERO) |=> state == ebr_pkg::LS_WAIT)
      else $error("ready sampled before programmed waitstates");

   a_mux_post: assert property (@(posedge LCLK) disable iff (!RST_N)
      (ended && c_mux && c_tri) |=> (state == ebr_pkg::LS_MUX) [*2]
                                    ##1 (state == ebr_pkg::LS_TRI) [*2]
                                    ##1 (state == ebr_pkg::LS_IDLE))
      else $error("post-cycle delay not two reference cycles");

   a_demux_post: assert property (@(posedge LCLK) disable iff (!RST_N)
      (ended && !c_mux && !c_tri) |=> state == ebr_pkg::LS_IDLE)
      else $error("demultiplexed cycle added a delay");

   a_finish_first: assert property (@(posedge LCLK) disable iff (!RST_N)
      $rose(state == ebr_pkg::LS_REL) |-> $past(state) == ebr_pkg::LS_IDLE)
      else $error("bus released inside a cycle");

   a_cs_release: assert property (@(posedge LCLK) disable iff (!RST_N)
      (state == ebr_pkg::LS_REL) |-> (CS_N && CS_OE && !BUS_OE) ##1 !CS_OE)
      else $error("chip select not driven high for one tick");

   a_grant_after: assert property (@(posedge LCLK) disable iff (!RST_N)
      $fell(GRANT_ACK_N) |-> !BUS_OE && !CS_OE && $past(state) == ebr_pkg::LS_REL)
      else $error("grant before outputs released");

   a_regain_wait: assert property (@(posedge LCLK) disable iff (!RST_N)
      (state == ebr_pkg::LS_HELD && !hold_s) |=> state == ebr_pkg::LS_HELD)
      else $error("regain started while request active");

   a_regain_go: assert property (@(posedge LCLK) disable iff (!RST_N)
      (state == ebr_pkg::LS_HELD && hold_s) |=> GRANT_ACK_N && BUS_OE
                                                ##[1:2] state == ebr_pkg::LS_IDLE)
      else $error("regain sequence did not run");
endmodule

// file: sim/ebr_mem_model.sv
`timescale 1ns/1ps
// Far-side memory: answers each strobe with ready after a set number of reference periods
module ebr_mem_model (
   // Bus side
   input  wire logic       ref_clk,
   input  wire logic       rd_strobe_n,
   input  wire logic       wr_strobe_n,
   output logic            ready_n,
   // Bench control, reference periods before ready goes low
   input  wire logic [3:0] ready_delay
);
   logic [3:0] cnt;
   wire        strobe_on = !rd_strobe_n || !wr_strobe_n;

   initial ready_n = 1'b1;
   initial cnt = 4'h0;

   // Ready moves only just after a reference edge, so a direct sampler sees a clean level;
   // once low it stays low until the strobe ends, which is at least half a period later
   always @(posedge ref_clk or negedge strobe_on) begin
      if (!strobe_on) begin
         cnt     <= 4'h0;
         ready_n <= 1'b1;
      end else if (cnt == ready_delay) begin
         ready_n <= 1'b0;
      end else begin
         cnt <= cnt + 4'h1;
      end
   end
endmodule

// file: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   // Clocks, reset and register port
   logic        clk, lclk, rst_n, wr, rd;
   logic [1:0]  addr;
   logic [15:0] wdata, rdata;
   // Link bus and arbitration
   logic        ref_clk, ready_n, rd_strobe_n, wr_strobe_n, bus_oe, cs_n, cs_oe;
   logic        hold_n, grant_ack_n, regain_req_n, x_rd_n, x_wr_n, x_doe, last_wr;
   logic [3:0]  x_addr, ready_delay, n_done;
   logic [15:0] x_din, x_dout, base_len;
   int          n_errors, compares;
   time         t_fall, t_rise, t_busoff, t_csoff;

   // Chip select has a pull-up, so a released line reads high
   wire       strobe_on = !rd_strobe_n || !wr_strobe_n;
   wire       cs_wire   = cs_oe ? cs_n : 1'b1;
   wire [3:0] watch     = {bus_oe, regain_req_n, grant_ack_n, strobe_on};

   ebr_ctrl dut (
      .CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
      .LCLK(lclk), .BUS_REF_CLK(ref_clk), .READY_N(ready_n), .RD_STROBE_N(rd_strobe_n),
      .WR_STROBE_N(wr_strobe_n), .BUS_OE(bus_oe), .CS_N(cs_n), .CS_OE(cs_oe),
      .HOLD_N(hold_n), .GRANT_ACK_N(grant_ack_n), .REGAIN_REQ_N(regain_req_n),
      .X_ADDR(x_addr), .X_DIN(x_din), .X_RD_N(x_rd_n), .X_WR_N(x_wr_n), .X_DOUT(x_dout),
      .X_DOE(x_doe)
   );

   ebr_mem_model u_mem (
      .ref_clk(ref_clk), .rd_strobe_n(rd_strobe_n), .wr_strobe_n(wr_strobe_n),
      .ready_n(ready_n), .ready_delay(ready_delay)
   );

   // Clocks; the link clock starts off-phase so the two never line up
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      lclk = 1'b0;
      #37;
      // First edge falls inside reset, so the link side is reset by a clock edge too
      forever begin
         lclk = ~lclk;
         #80;
      end
   end

   // Edge time stamps; strobes only move on reference steps, so spans are whole periods
   always @(posedge strobe_on) begin
      t_fall  = $time;
      last_wr = !wr_strobe_n;
   end
   always @(negedge strobe_on) t_rise = $time;
   always @(negedge bus_oe) t_busoff = $time;
   always @(negedge cs_oe) t_csoff = $time;

   task automatic results;
      $display("comparisons %0d, mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic timeout;
      n_errors++;
      $display("wait limit reached");
      results();
   endtask

   // Register port; a spare edge after each access keeps strobes from being set twice at once
   task automatic reg_wr(input logic [1:0] a, input logic [15:0] d);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask

   task automatic reg_rd(input logic [1:0] a, output logic [15:0] d);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      d = rdata;
   endtask

   // Bounded wait on one watched design output
   task automatic wait_for(input int k, input logic v);
      int i;
      for (i = 0; i < 4000 && watch[k] !== v; i++) @(posedge clk);
      if (watch[k] !== v) timeout();
   endtask

   // Starts one cycle and returns strobe span and post-cycle delay, both in reference periods
   task automatic run_cycle(input logic [15:0] ctrl, input logic dir,
                            output logic [15:0] len, output logic [15:0] post);
      logic [15:0] s;
      int          i;
      reg_wr(ebr_pkg::REG_CTRL, ctrl);
      reg_wr(ebr_pkg::REG_CMD, {14'h0000, dir, 1'b1});
      s = 16'h0001;
      for (i = 0; i < 500 && s[0] !== 1'b0; i++) reg_rd(ebr_pkg::REG_STAT, s);
      n_done++;
      len  = 16'((t_rise - t_fall) / 320);
      post = 16'(($time - t_rise + 160) / 320);
      if (s[0] !== 1'b0) timeout();
   endtask

   // External master on the shared RAM; each access spans 13 clocks, above 60 ns
   task automatic x_write(input logic [3:0] a, input logic [15:0] d);
      x_addr <= a;
      x_din  <= d;
      @(posedge clk);
      x_wr_n <= 1'b0;
      repeat (6) @(posedge clk);
      x_wr_n <= 1'b1;
      repeat (2) @(posedge clk);
      x_din <= ~d; // Data no longer valid after hold
      repeat (4) @(posedge clk);
   endtask

   task automatic x_read(input logic [3:0] a, input logic [15:0] exp, input logic en);
      x_addr <= a;
      @(posedge clk);
      x_rd_n <= 1'b0;
      repeat (8) @(posedge clk);
      check("ram drive", {15'h0000, x_doe}, {15'h0000, en});
      if (en) check("ram data", x_dout, exp);
      x_rd_n <= 1'b1;
      repeat (4) @(posedge clk);
   endtask

   task automatic test_reset;
      logic [15:0] d;
      check("idle outputs", {12'h000, rd_strobe_n, wr_strobe_n, cs_n, cs_oe}, 16'h000F);
      check("idle arbitration", {13'h0000, grant_ack_n, regain_req_n, x_doe}, 16'h0006);
      reg_rd(ebr_pkg::REG_CTRL, d);
      check("ctrl reset", d, ebr_pkg::CTRL_RESET);
      reg_wr(ebr_pkg::REG_CTRL, 16'hFFFF);
      reg_rd(ebr_pkg::REG_CTRL, d);
      check("ctrl mask", d, ebr_pkg::CTRL_MASK);
      reg_rd(2'h3, d);
      check("unmapped read", d, 16'h0000);
      $display("test reset done");
   endtask

   task automatic test_ready;
      logic [15:0] l, p;
      run_cycle(16'h0000, 1'b0, base_len, p);
      check("demux post delay", p, 16'h0000);
      run_cycle(16'h0200, 1'b1, l, p);
      check("waitstate span", l - base_len, 16'h0002);
      check("write strobe", {15'h0000, last_wr}, 16'h0001);
      ready_delay <= 4'h4;
      run_cycle(16'h0000, 1'b0, l, p);
      check("ready wait span", l - base_len, 16'h0003);
      ready_delay <= 4'h0;
      run_cycle(16'h0001, 1'b0, l, p);
      check("async slower", {15'h0000, l > base_len}, 16'h0001);
      run_cycle(16'h0002, 1'b0, l, p);
      check("mux post delay", p, 16'h0001);
      run_cycle(16'h0006, 1'b0, l, p);
      check("tristate post delay", p, 16'h0002);
      reg_rd(ebr_pkg::REG_STAT, p);
      check("status count", p, {8'h00, n_done, 4'h0});
      $display("test ready done");
   endtask

   task automatic test_hold;
      logic [15:0] d;
      ready_delay <= 4'h4;
      reg_wr(ebr_pkg::REG_CTRL, 16'h0018);
      reg_wr(ebr_pkg::REG_CMD, 16'h0001);
      wait_for(0, 1'b1);
      hold_n <= 1'b0;
      wait_for(1, 1'b0);
      check("grant after cycle", {15'h0000, t_busoff > t_rise}, 16'h0001);
      check("select high time", 16'(t_csoff - t_busoff), 16'h00A0);
      check("released pins", {13'h0000, cs_wire, bus_oe, cs_oe}, 16'h0004);
      wait_for(2, 1'b0);
      x_write(4'h5, 16'hA5C3);
      x_write(4'hA, 16'h3C5A);
      x_read(4'h5, 16'hA5C3, 1'b1);
      x_read(4'hA, 16'h3C5A, 1'b1);
      reg_rd(ebr_pkg::REG_STAT, d);
      check("held flag", d & 16'h0003, 16'h0002);
      check("still granted", {15'h0000, grant_ack_n}, 16'h0000);
      hold_n <= 1'b1;
      wait_for(1, 1'b1);
      check("regained", {14'h0000, regain_req_n, bus_oe}, 16'h0003);
      x_read(4'h5, 16'h0000, 1'b0);
      ready_delay <= 4'h0;
      $display("test hold done");
   endtask

   task automatic test_regain_only;
      logic [15:0] l, p;
      reg_wr(ebr_pkg::REG_CTRL, 16'h0000);
      hold_n <= 1'b0;
      wait_for(1, 1'b0);
      hold_n <= 1'b1;
      check("no regain request", {15'h0000, regain_req_n}, 16'h0001);
      wait_for(1, 1'b1);
      run_cycle(16'h0000, 1'b0, l, p);
      check("cycle after regain", l, base_len);
      $display("test regain done");
   endtask

   // Main sequence
   initial begin
      rst_n = 1'b0;
      {wr, rd, addr, wdata, x_addr, x_din, ready_delay, n_done} = '0;
      {hold_n, x_rd_n, x_wr_n} = 3'b111;
      n_errors = 0;
      compares = 0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      test_reset();
      test_ready();
      test_hold();
      test_regain_only();
      results();
   end
endmodule
